// ### twb_regs.svh
// Register offsets, field positions, reset values, status codes and timing of the byte engine
`ifndef TWB_REGS_SVH
`define TWB_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define TWB_OFF_CTRL 3'h0
`define TWB_OFF_STAT 3'h1
`define TWB_OFF_DATA 3'h2
`define TWB_OFF_OWN 3'h3

// ****************************************
// Control fields
// ****************************************
`define TWB_CTRL_FLAG 7
`define TWB_CTRL_ACK 6
`define TWB_CTRL_STA 5
`define TWB_CTRL_STO 4
`define TWB_CTRL_EN 2
`define TWB_CTRL_IE 0

// ****************************************
// Reset values
// ****************************************
`define TWB_RST_OWN 7'h00
`define TWB_RST_DATA 8'hff

// ****************************************
// Status codes
// ****************************************
`define TWB_ST_NONE 8'hf8
`define TWB_ST_START 8'h08
`define TWB_ST_ADDR_ACK 8'h18
`define TWB_ST_ADDR_NACK 8'h20
`define TWB_ST_DATA_ACK 8'h28
`define TWB_ST_DATA_NACK 8'h30
`define TWB_ST_ARB_LOST 8'h38
`define TWB_ST_RX_ACK 8'h50
`define TWB_ST_RX_NACK 8'h58
`define TWB_ST_ARB_ADDR 8'h68
`define TWB_ST_SLV_ACK 8'h80
`define TWB_ST_SLV_NACK 8'h88

// ****************************************
// Timing
// ****************************************
`define TWB_CLK_NS 4
`define TWB_HALF_NS 5000
`define TWB_HALF_CYC ((`TWB_HALF_NS + `TWB_CLK_NS - 1) / `TWB_CLK_NS)

`endif

// ### twb_pkg.sv
// Types of the byte engine: controller states and the packed state record
package twb_pkg;

  typedef enum logic [3:0] {
    IDLE, RSTART, START_HI, START_LO, BIT_LO, BIT_HI,
    HOLD, STOP_LO, STOP_HI, STOP_END, SLV
  } state_e;

  typedef struct packed {
    state_e st;
    logic scl_m;
    logic sda_m;
    logic scl_s;
    logic sda_s;
    logic scl_p;
    logic sda_p;
    logic busy;
    logic [10:0] cnt;
    logic seen;
    logic [3:0] idx;
    logic [7:0] shreg;
    logic flag;
    logic [7:0] code;
    logic [7:0] status;
    logic sta;
    logic sto;
    logic ack_en;
    logic en;
    logic ie;
    logic [6:0] own_addr;
    logic addr_ph;
    logic rx;
    logic slave;
    logic matched;
    logic scl_oe;
    logic sda_oe;
    logic pin_lvl;
    logic irq;
    logic [7:0] rdata;
  } state_s;

endpackage

// ### two_wire_byte_transfer_engine.sv
// Byte-oriented two-wire bus engine: master transfer, arbitration and slave follow-on
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "twb_regs.svh"

module two_wire_byte_transfer_engine (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Interrupt request
  input wire logic i_global_ie,
  output logic o_irq,
  // Bus pins
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe
);

  localparam logic [10:0] HALF_LAST = 11'(`TWB_HALF_CYC - 1);

  twb_pkg::state_s r_q;
  twb_pkg::state_s r_d;
  logic set_ev;
  logic clr;
  logic half_done;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic tx;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    r_d = r_q;
    set_ev = 1'b0;
    r_d.scl_m = i_scl;
    r_d.sda_m = i_sda;
    r_d.scl_s = r_q.scl_m;
    r_d.sda_s = r_q.sda_m;
    r_d.scl_p = r_q.scl_s;
    r_d.sda_p = r_q.sda_s;
    r_d.pin_lvl = 1'b0;
    rise = r_q.scl_s & ~r_q.scl_p;
    fall = ~r_q.scl_s & r_q.scl_p;
    start_det = r_q.scl_s & r_q.scl_p & r_q.sda_p & ~r_q.sda_s;
    stop_det = r_q.scl_s & r_q.scl_p & ~r_q.sda_p & r_q.sda_s;
    half_done = (r_q.cnt == HALF_LAST);
    tx = r_q.addr_ph | ~r_q.rx;
    r_d.irq = r_q.flag & r_q.ie & i_global_ie;
    r_d.status = r_q.flag ? r_q.code : `TWB_ST_NONE;
    if (start_det)
      r_d.busy = 1'b1;
    else if (stop_det)
      r_d.busy = 1'b0;
    // Register reads answer in the next cycle only
    r_d.rdata = 8'h00;
    if (i_rd)
    begin
      unique case (i_addr)
        `TWB_OFF_CTRL: r_d.rdata = {r_q.flag, r_q.ack_en, r_q.sta, r_q.sto,
                                    1'b0, r_q.en, 1'b0, r_q.ie};
        `TWB_OFF_STAT: r_d.rdata = r_q.status;
        `TWB_OFF_DATA: r_d.rdata = r_q.shreg;
        `TWB_OFF_OWN: r_d.rdata = {r_q.own_addr, 1'b0};
        default: r_d.rdata = 8'h00;
      endcase
    end
    clr = i_wr && (i_addr == `TWB_OFF_CTRL) && i_wdata[`TWB_CTRL_FLAG];
    if (i_wr && (i_addr == `TWB_OFF_CTRL))
    begin
      r_d.ack_en = i_wdata[`TWB_CTRL_ACK];
      r_d.sta = i_wdata[`TWB_CTRL_STA];
      r_d.sto = i_wdata[`TWB_CTRL_STO];
      r_d.en = i_wdata[`TWB_CTRL_EN];
      r_d.ie = i_wdata[`TWB_CTRL_IE];
    end
    if (i_wr && (i_addr == `TWB_OFF_DATA))
      r_d.shreg = i_wdata;
    if (i_wr && (i_addr == `TWB_OFF_OWN))
      r_d.own_addr = i_wdata[7:1];
    r_d.cnt = r_q.cnt + 11'h001;
    unique case (r_q.st)
      twb_pkg::IDLE:
      begin
        r_d.scl_oe = 1'b0;
        r_d.sda_oe = 1'b0;
        r_d.slave = 1'b0;
        if (r_q.en && r_q.sta && !r_q.flag && !r_q.busy)
        begin
          r_d.st = twb_pkg::START_HI;
          r_d.seen = 1'b0;
        end
      end
      twb_pkg::RSTART:
      begin
        r_d.sda_oe = 1'b0;
        if (half_done)
        begin
          r_d.st = twb_pkg::START_HI;
          r_d.scl_oe = 1'b0;
          r_d.seen = 1'b0;
        end
      end
      twb_pkg::START_HI:
      begin
        if (!r_q.seen)
        begin
          r_d.seen = r_q.scl_s;
          r_d.cnt = 11'h000;
        end
        else if (half_done)
        begin
          r_d.st = twb_pkg::START_LO;
          r_d.sda_oe = 1'b1;
          r_d.cnt = 11'h000;
        end
      end
      twb_pkg::START_LO:
      begin
        if (half_done)
        begin
          r_d.st = twb_pkg::HOLD;
          r_d.scl_oe = 1'b1;
          r_d.code = `TWB_ST_START;
          set_ev = 1'b1;
          r_d.addr_ph = 1'b1;
          r_d.matched = 1'b0;
        end
      end
      twb_pkg::BIT_LO:
      begin
        r_d.scl_oe = 1'b1;
        if (r_q.idx == 4'h8)
          r_d.sda_oe = r_q.rx & ~r_q.addr_ph & r_q.ack_en;
        else
          r_d.sda_oe = tx & ~r_q.shreg[7];
        if (half_done)
        begin
          r_d.st = twb_pkg::BIT_HI;
          r_d.scl_oe = 1'b0;
          r_d.seen = 1'b0;
        end
      end
      twb_pkg::BIT_HI:
      begin
        if (!r_q.seen)
        begin
          r_d.seen = r_q.scl_s;
          r_d.cnt = 11'h000;
        end
        else if (half_done || !r_q.scl_s)
        begin
          if (r_q.idx == 4'h8)
          begin
            r_d.st = twb_pkg::HOLD;
            r_d.scl_oe = 1'b1;
            set_ev = 1'b1;
            r_d.idx = 4'h0;
            r_d.addr_ph = 1'b0;
            if (r_q.addr_ph)
            begin
              r_d.rx = r_q.shreg[0];
              r_d.code = r_q.sda_s ? `TWB_ST_ADDR_NACK : `TWB_ST_ADDR_ACK;
            end
            else if (r_q.rx)
              r_d.code = r_q.sda_s ? `TWB_ST_RX_NACK : `TWB_ST_RX_ACK;
            else
              r_d.code = r_q.sda_s ? `TWB_ST_DATA_NACK : `TWB_ST_DATA_ACK;
          end
          else
          begin
            r_d.shreg = {r_q.shreg[6:0], r_q.sda_s};
            r_d.idx = r_q.idx + 4'h1;
            if (tx && !r_q.sda_oe && !r_q.sda_s)
            begin
              r_d.st = twb_pkg::SLV;
              r_d.slave = 1'b1;
              r_d.matched = 1'b0;
              r_d.scl_oe = 1'b0;
              r_d.sda_oe = 1'b0;
            end
            else
            begin
              r_d.st = twb_pkg::BIT_LO;
              r_d.scl_oe = 1'b1;
              r_d.cnt = 11'h000;
            end
          end
        end
      end
      twb_pkg::HOLD:
      begin
        r_d.scl_oe = 1'b1;
        r_d.sda_oe = 1'b0;
        r_d.cnt = 11'h000;
        if (!r_q.flag)
        begin
          if (r_q.slave)
          begin
            r_d.scl_oe = 1'b0;
            r_d.idx = 4'h0;
            r_d.st = r_q.matched ? twb_pkg::SLV : twb_pkg::IDLE;
          end
          else if (r_q.sta)
            r_d.st = twb_pkg::RSTART;
          else if (r_q.sto)
            r_d.st = twb_pkg::STOP_LO;
          else
          begin
            r_d.st = twb_pkg::BIT_LO;
            r_d.idx = 4'h0;
          end
        end
      end
      twb_pkg::STOP_LO:
      begin
        r_d.sda_oe = 1'b1;
        if (half_done)
        begin
          r_d.st = twb_pkg::STOP_HI;
          r_d.scl_oe = 1'b0;
          r_d.seen = 1'b0;
        end
      end
      twb_pkg::STOP_HI:
      begin
        if (!r_q.seen)
        begin
          r_d.seen = r_q.scl_s;
          r_d.cnt = 11'h000;
        end
        else if (half_done)
        begin
          r_d.st = twb_pkg::STOP_END;
          r_d.sda_oe = 1'b0;
          r_d.cnt = 11'h000;
        end
      end
      twb_pkg::STOP_END:
      begin
        if (half_done)
        begin
          r_d.st = twb_pkg::IDLE;
          r_d.sto = 1'b0;
        end
      end
      twb_pkg::SLV:
      begin
        r_d.scl_oe = 1'b0;
        if (stop_det)
          r_d.st = twb_pkg::IDLE;
        else if (start_det)
        begin
          r_d.idx = 4'h0;
          r_d.addr_ph = 1'b1;
          r_d.matched = 1'b0;
        end
        else if (rise && r_q.idx < 4'h8)
        begin
          r_d.shreg = {r_q.shreg[6:0], r_q.sda_s};
          r_d.idx = r_q.idx + 4'h1;
        end
        else if (fall && r_q.idx == 4'h8)
        begin
          r_d.idx = 4'h9;
          if (r_q.addr_ph)
          begin
            r_d.matched = (r_q.shreg[7:1] == r_q.own_addr) & ~r_q.shreg[0];
            r_d.sda_oe = (r_q.shreg[7:1] == r_q.own_addr) & ~r_q.shreg[0];
          end
          else
            r_d.sda_oe = r_q.matched & r_q.ack_en;
        end
        else if (fall && r_q.idx == 4'h9)
        begin
          r_d.st = twb_pkg::HOLD;
          r_d.scl_oe = 1'b1;
          r_d.sda_oe = 1'b0;
          set_ev = 1'b1;
          r_d.addr_ph = 1'b0;
          if (!r_q.matched)
            r_d.code = `TWB_ST_ARB_LOST;
          else if (r_q.addr_ph)
            r_d.code = `TWB_ST_ARB_ADDR;
          else
            r_d.code = r_q.sda_oe ? `TWB_ST_SLV_ACK : `TWB_ST_SLV_NACK;
        end
      end
    endcase
    if (!r_q.en && r_q.st != twb_pkg::HOLD)
    begin
      r_d.st = twb_pkg::IDLE;
      r_d.scl_oe = 1'b0;
      r_d.sda_oe = 1'b0;
    end
    r_d.flag = set_ev | (r_q.flag & ~clr);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      r_q <= '0;
      r_q.own_addr <= `TWB_RST_OWN;
      r_q.shreg <= `TWB_RST_DATA;
      r_q.status <= `TWB_ST_NONE;
      r_q.code <= `TWB_ST_NONE;
      // Pin history starts at the idle level so no false edge follows reset
      r_q.scl_m <= 1'b1;
      r_q.sda_m <= 1'b1;
      r_q.scl_s <= 1'b1;
      r_q.sda_s <= 1'b1;
      r_q.scl_p <= 1'b1;
      r_q.sda_p <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  assign o_rdata = r_q.rdata;
  assign o_irq = r_q.irq;
  assign o_scl_out = r_q.pin_lvl;
  assign o_sda_out = r_q.pin_lvl;
  assign o_scl_oe = r_q.scl_oe;
  assign o_sda_oe = r_q.sda_oe;

  // ****************************************
  // Checks
  // ****************************************
  a_flag_holds_scl: assert property (@(posedge i_clk) disable iff (!i_resetn)
    r_q.flag && $past(r_q.flag) |-> r_q.scl_oe)
    else $error("SCL released while event flag set");

  a_status_lag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(r_q.flag) |=> r_q.status == $past(r_q.code))
    else $error("status not loaded one cycle after flag");

  a_status_none: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !r_q.flag ##1 !r_q.flag |-> r_q.status == `TWB_ST_NONE)
    else $error("status not no-info while flag clear");

  a_no_op_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    r_q.flag && $past(r_q.flag) |-> r_q.st == twb_pkg::HOLD || r_q.st == twb_pkg::IDLE)
    else $error("operation ran while flag set");

  a_stop_no_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(r_q.st) == twb_pkg::STOP_END && r_q.st == twb_pkg::IDLE |-> !$rose(r_q.flag))
    else $error("flag set after stop");

  a_nine_bits: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(r_q.st) == twb_pkg::BIT_HI && r_q.st == twb_pkg::HOLD |-> $past(r_q.idx) == 4'h8)
    else $error("packet ended off the ninth bit");

  a_lose_high: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(r_q.st) == twb_pkg::BIT_HI && r_q.st == twb_pkg::SLV
      |-> !$past(r_q.sda_oe) && !$past(r_q.sda_s))
    else $error("arbitration lost while driving low");

  a_lost_release: assert property (@(posedge i_clk) disable iff (!i_resetn)
    r_q.st == twb_pkg::SLV && !r_q.matched && r_q.idx != 4'h9 |-> !r_q.sda_oe)
    else $error("SDA driven after arbitration loss");

  a_start_code: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(r_q.st) == twb_pkg::START_LO && r_q.st == twb_pkg::HOLD
      |-> r_q.flag && r_q.code == `TWB_ST_START ##1 r_q.status == `TWB_ST_START)
    else $error("start not reported");

endmodule // two_wire_byte_transfer_engine

`default_nettype wire

// ### twb_bus_partner.sv
// Bus partner: addressed slave and optional rival master on the two wires
`timescale 1ns/1ps
`default_nettype none

module twb_bus_partner (
  // Wires
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_pull,
  output logic o_sda_pull,
  // Behaviour
  input wire logic i_rival_en,
  input wire logic [7:0] i_rival_byte,
  input wire logic [1:0] i_ack_mask,
  input wire logic i_stretch,
  // Observation
  output logic [7:0] o_rx_byte,
  output logic [7:0] o_rises,
  output logic o_stop_seen
);
  int bitn = 0;
  int pkt = 0;
  logic rival_pull = 1'b0;
  logic hold_low = 1'b0;

  assign o_scl_pull = rival_pull | hold_low;

  initial
  begin
    o_sda_pull = 1'b0;
    o_rx_byte = 8'h00;
    o_rises = 8'h00;
    o_stop_seen = 1'b0;
  end

  // ****************************************
  // Framing, data and acknowledge
  // ****************************************
  always @(negedge i_sda)
    if (i_scl === 1'b1)
    begin
      bitn = 0;
      pkt = 0;
      o_rises = 8'h00;
      o_stop_seen = 1'b0;
    end

  always @(posedge i_sda)
    if (i_scl === 1'b1)
      o_stop_seen = 1'b1;

  always @(posedge i_scl)
  begin
    o_rises = o_rises + 8'h01;
    if (bitn < 8)
      o_rx_byte = {o_rx_byte[6:0], i_sda};
    bitn = bitn + 1;
  end

  // Only the receiver answers in the ninth period; released level means refusal
  always @(negedge i_scl)
  begin
    // Hold time: the engine still samples the old bit just after SCL falls
    #8;
    if (bitn == 8)
    begin
      o_sda_pull = i_ack_mask[pkt != 0];
      if (pkt == 1 && i_stretch)
      begin
        hold_low = 1'b1;
        #20000;
        hold_low = 1'b0;
      end
    end
    else
    begin
      if (bitn == 9)
      begin
        bitn = 0;
        pkt = pkt + 1;
      end
      o_sda_pull = i_rival_en && pkt == 0 && !i_rival_byte[7 - bitn];
    end
  end

  // Rival clock: 32 ns period, counted from the wired line's own edges
  always @(negedge i_sda)
    if (i_scl === 1'b1 && i_rival_en)
    begin
      wait (i_scl == 1'b0);
      repeat (9)
      begin
        rival_pull = 1'b1;
        #16;
        rival_pull = 1'b0;
        wait (i_scl == 1'b1);
        #16;
      end
      rival_pull = 1'b1;
      #16;
      rival_pull = 1'b0;
    end
endmodule // twb_bus_partner

`default_nettype wire

// ### tb_top.sv
// Bench of the two-wire byte engine with a partner on its bus
`timescale 1ns/1ps
`default_nettype none
`include "twb_regs.svh"

module tb_top;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_global_ie = 1'b0;
  logic rival_en = 1'b0;
  logic stretch = 1'b0;
  logic [7:0] rival_byte = 8'h00;
  logic [1:0] ack_mask = 2'b11;
  logic [7:0] o_rdata, rx_byte, rises, rd;
  logic o_irq, o_scl_out, o_scl_oe, o_sda_out, o_sda_oe;
  logic scl_bus, sda_bus, p_scl, p_sda, stop_seen;
  int fail_count = 0;
  int compares = 0;

  always #2 i_clk = ~i_clk;
  assign scl_bus = ~((o_scl_oe & ~o_scl_out) | p_scl);
  assign sda_bus = ~((o_sda_oe & ~o_sda_out) | p_sda);

  two_wire_byte_transfer_engine dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_ie(i_global_ie),
    .o_irq(o_irq), .i_scl(scl_bus), .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe),
    .i_sda(sda_bus), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe)
  );

  twb_bus_partner partner (
    .i_scl(scl_bus), .i_sda(sda_bus), .o_scl_pull(p_scl), .o_sda_pull(p_sda),
    .i_rival_en(rival_en), .i_rival_byte(rival_byte), .i_ack_mask(ack_mask),
    .i_stretch(stretch), .o_rx_byte(rx_byte), .o_rises(rises),
    .o_stop_seen(stop_seen)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd_reg(input logic [2:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd = o_rdata;
    @(posedge i_clk);
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    rd = 8'h00;
    while (rd[`TWB_CTRL_FLAG] !== 1'b1)
    begin
      n++;
      if (n > 20000)
      begin
        fail_count++;
        stop_test();
      end
      rd_reg(`TWB_OFF_CTRL);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd_reg(`TWB_OFF_STAT);
    chk(rd, `TWB_ST_NONE);
    rd_reg(`TWB_OFF_DATA);
    chk(rd, `TWB_RST_DATA);
    rd_reg(3'h5);
    chk(rd, 8'h00);
    chk({6'h00, scl_bus, sda_bus}, 8'h03);
    chk({6'h00, o_scl_out, o_sda_out}, 8'h00);
  endtask

  task automatic t_write();
    ack_mask <= 2'b01;
    stretch <= 1'b1;
    wr_reg(`TWB_OFF_CTRL, 8'ha5);
    wait_flag();
    rd_reg(`TWB_OFF_STAT);
    chk(rd, `TWB_ST_START);
    chk({7'h00, o_irq}, 8'h00);
    i_global_ie <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk({7'h00, o_irq}, 8'h01);
    wr_reg(`TWB_OFF_DATA, 8'h5a);
    // Control write without the flag bit leaves the bus parked
    wr_reg(`TWB_OFF_CTRL, 8'h05);
    repeat (3000) @(posedge i_clk);
    chk({7'h00, scl_bus}, 8'h00);
    chk(rises, 8'h00);
    wr_reg(`TWB_OFF_CTRL, 8'h85);
    wait_flag();
    rd_reg(`TWB_OFF_STAT);
    chk(rd, `TWB_ST_ADDR_ACK);
    chk(rx_byte, 8'h5a);
    chk(rises, 8'h09);
    wr_reg(`TWB_OFF_DATA, 8'hc3);
    wr_reg(`TWB_OFF_CTRL, 8'h85);
    wait_flag();
    rd_reg(`TWB_OFF_STAT);
    chk(rd, `TWB_ST_DATA_NACK);
    chk(rx_byte, 8'hc3);
    chk(rises, 8'h12);
    wr_reg(`TWB_OFF_CTRL, 8'h94);
    repeat (6000) @(posedge i_clk);
    chk({7'h00, stop_seen}, 8'h01);
    rd_reg(`TWB_OFF_CTRL);
    chk(rd & 8'h80, 8'h00);
    rd_reg(`TWB_OFF_STAT);
    chk(rd, `TWB_ST_NONE);
  endtask

  // Rival wins at bit 3; bit 4 (engine low, rival high) must not cost it
  task automatic t_arb();
    rival_byte <= 8'h52;
    rival_en <= 1'b1;
    ack_mask <= 2'b00;
    wr_reg(`TWB_OFF_CTRL, 8'ha4);
    wait_flag();
    wr_reg(`TWB_OFF_DATA, 8'h48);
    wr_reg(`TWB_OFF_CTRL, 8'h84);
    wait_flag();
    rd_reg(`TWB_OFF_STAT);
    chk(rd, `TWB_ST_ARB_LOST);
    chk(rx_byte, 8'h42);
    chk(rises, 8'h09);
  endtask

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_reset();
    t_write();
    t_arb();
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
